// ---- core/can_fd_irq_pkg.sv ----
`default_nettype none

package can_fd_irq_pkg;

	// Register indices on the internal register port
	localparam logic [2:0] REG_TIME_BASE_COUNT       = 3'h0;
	localparam logic [2:0] REG_TIMESTAMP_CONTROL     = 3'h1;
	localparam logic [2:0] REG_INTERRUPT_CODE_VECTOR = 3'h2;
	localparam logic [2:0] REG_INTERRUPT_ENABLE_FLAG = 3'h3;
	localparam logic [2:0] REG_RECEIVE_FIFO_PENDING  = 3'h4;
	localparam logic [2:0] REG_TRANSMIT_FIFO_PENDING = 3'h5;

	// Timestamp control fields
	localparam int TS_RES_POS     = 18;
	localparam int TS_EOF_POS     = 17;
	localparam int TB_ENABLE_POS  = 16;
	localparam int TB_PRESCALE_HI = 9;

	// Interrupt register flag positions; enables sit this far above
	localparam int ENABLE_SHIFT    = 16;
	localparam int INVALID_MSG_POS = 15;
	localparam int WAKEUP_POS      = 14;
	localparam int BUS_ERROR_POS   = 13;
	localparam int SYS_ERROR_POS   = 12;
	localparam int RX_OVERFLOW_POS = 11;
	localparam int TX_ATTEMPT_POS  = 10;
	localparam int LINK_CRC_POS    = 9;
	localparam int RAM_ECC_POS     = 8;
	localparam int TX_EVENT_POS    = 4;
	localparam int MODE_CHANGE_POS = 3;
	localparam int TB_OVERFLOW_POS = 2;
	localparam int RX_SUMMARY_POS  = 1;
	localparam int TX_SUMMARY_POS  = 0;

	// Implemented enable bits of the upper half-word
	localparam logic [15:0] ENABLE_MASK = 16'hFF1F;

	// Reset values, and the count at which the time base wraps
	localparam logic [15:0] ENABLE_RESET     = 16'h0000;
	localparam logic [9:0]  PRESCALE_RESET   = 10'h000;
	localparam logic [31:0] COUNT_RESET      = 32'h0000_0000;
	localparam logic [31:0] COUNT_MAX        = 32'hFFFF_FFFF;
	localparam logic [2:0]  OPMODE_RESET     = 3'h0;

	// Source codes
	localparam logic [6:0] CODE_TX_ATTEMPT  = 7'h4A;
	localparam logic [6:0] CODE_TX_EVENT    = 7'h49;
	localparam logic [6:0] CODE_INVALID_MSG = 7'h48;
	localparam logic [6:0] CODE_MODE_CHANGE = 7'h47;
	localparam logic [6:0] CODE_TB_OVERFLOW = 7'h46;
	localparam logic [6:0] CODE_BUFFER_OVF  = 7'h45;
	localparam logic [6:0] CODE_ADDR_ERROR  = 7'h44;
	localparam logic [6:0] CODE_RX_OVERFLOW = 7'h43;
	localparam logic [6:0] CODE_WAKEUP      = 7'h42;
	localparam logic [6:0] CODE_BUS_ERROR   = 7'h41;
	localparam logic [6:0] CODE_NONE        = 7'h40;

endpackage

`default_nettype wire

// ---- core/time_base_counter.sv ----
`timescale 1ns/1ps
`default_nettype none

module time_base_counter (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        enable,
	input  wire logic [9:0]  prescale,
	input  wire logic        load,
	input  wire logic [31:0] load_value,
	output logic      [31:0] count,
	output logic             wrap
);

	logic [9:0] presc_cnt;
	wire        tick      = enable & ~load & (presc_cnt == prescale);
	wire        at_max    = (count == can_fd_irq_pkg::COUNT_MAX);

	// Prescaler and counter; disable holds both at zero
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			count     <= can_fd_irq_pkg::COUNT_RESET;
			presc_cnt <= can_fd_irq_pkg::PRESCALE_RESET;
			wrap      <= 1'b0;
		end else if (!enable) begin
			count     <= can_fd_irq_pkg::COUNT_RESET;
			presc_cnt <= can_fd_irq_pkg::PRESCALE_RESET;
			wrap      <= 1'b0;
		end else if (load) begin
			count     <= load_value;
			presc_cnt <= can_fd_irq_pkg::PRESCALE_RESET;
			wrap      <= 1'b0;
		end else if (tick) begin
			count     <= count + 32'h0000_0001;
			presc_cnt <= can_fd_irq_pkg::PRESCALE_RESET;
			wrap      <= at_max;
		end else begin
			presc_cnt <= presc_cnt + 10'h001;
			wrap      <= 1'b0;
		end
	end

	AST_TB_STOP: assert property (@(posedge sys_clk) disable iff (!rstn)
		!enable |=> count == 32'h0000_0000)
		else $error("time base not cleared while disabled");

	AST_TB_INC: assert property (@(posedge sys_clk) disable iff (!rstn)
		(enable && !load && presc_cnt == prescale) |=> count == $past(count) + 32'h0000_0001)
		else $error("time base did not advance on prescaler period");

	AST_PRESC_CLR: assert property (@(posedge sys_clk) disable iff (!rstn)
		(enable && load) |=> (presc_cnt == 10'h000 && count == $past(load_value))
		##1 (presc_cnt == 10'h001 || count == $past(count, 1) + 32'h0000_0001 || !enable || load))
		else $error("prescaler not restarted by counter write");

endmodule

`default_nettype wire

// ---- core/can_fd_interrupt_and_time_base.sv ----
`timescale 1ns/1ps
`default_nettype none

module can_fd_interrupt_and_time_base (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [2:0]  reg_addr,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	input  wire logic [31:0] reg_wdata,
	input  wire logic [2:0]  operating_mode_field,
	input  wire logic        invalid_message_event,
	input  wire logic        wakeup_event,
	input  wire logic        bus_error_event,
	input  wire logic        buffer_overflow_event,
	input  wire logic        address_error_event,
	input  wire logic [31:0] receive_overflow_bits,
	input  wire logic [31:0] transmit_attempt_bits,
	input  wire logic        host_link_crc_pending,
	input  wire logic        ram_correction_pending,
	input  wire logic        transmit_event_pending,
	input  wire logic [31:0] receive_fifo_requests,
	input  wire logic [31:0] transmit_fifo_requests,
	output logic      [31:0] reg_rdata,
	output logic             reg_rvalid,
	output logic             interrupt_n
);

	// Highest set bit: {found, index}
	function automatic logic [5:0] highest(input logic [31:0] bits);
		logic [5:0] result;
		result = 6'h00;
		for (int i = 0; i < 32; i++) begin
			if (bits[i]) begin
				result = {1'b1, 5'(i)};
			end
		end
		return result;
	endfunction

	// Sticky flag update; a set in the clearing cycle wins
	function automatic logic sticky(input logic flag, input logic clr, input logic set);
		return (flag & ~clr) | set;
	endfunction

	// Fifo hit to seven-bit code
	function automatic logic [6:0] fifo_code(input logic [5:0] hit);
		return hit[5] ? {2'b00, hit[4:0]} : can_fd_irq_pkg::CODE_NONE;
	endfunction

	// Control and status state
	logic [15:0] enables;
	logic        invalid_message_flag;
	logic        wakeup_flag;
	logic        bus_error_flag;
	logic        system_error_flag;
	logic        system_error_is_buffer;
	logic        mode_change_flag;
	logic        time_base_overflow_flag;
	logic        ts_res;
	logic        ts_eof;
	logic        time_base_enable;
	logic [9:0]  time_base_prescale;
	logic [2:0]  opmode_prev;
	logic        opmode_seen;
	logic [31:0] receive_fifo_pending_bits;
	logic [31:0] transmit_fifo_pending_bits;
	logic        receive_overflow_flag;
	logic        transmit_attempt_flag;
	logic        host_link_crc_flag;
	logic        ram_correction_flag;
	logic        transmit_event_flag;
	logic        receive_summary_flag;
	logic        transmit_summary_flag;
	logic [6:0]  receive_source_code;
	logic [6:0]  transmit_source_code;
	logic [6:0]  interrupt_source_code;
	logic [31:0] time_base_counter;
	logic        tb_wrap;

	// Register port decode
	wire wr_count  = reg_write & (reg_addr == can_fd_irq_pkg::REG_TIME_BASE_COUNT);
	wire wr_tscon  = reg_write & (reg_addr == can_fd_irq_pkg::REG_TIMESTAMP_CONTROL);
	wire wr_int    = reg_write & (reg_addr == can_fd_irq_pkg::REG_INTERRUPT_ENABLE_FLAG);

	// Writing zero to a sticky flag clears it, one leaves it alone
	wire clr_ivm   = wr_int & ~reg_wdata[can_fd_irq_pkg::INVALID_MSG_POS];
	wire clr_wak   = wr_int & ~reg_wdata[can_fd_irq_pkg::WAKEUP_POS];
	wire clr_cerr  = wr_int & ~reg_wdata[can_fd_irq_pkg::BUS_ERROR_POS];
	wire clr_serr  = wr_int & ~reg_wdata[can_fd_irq_pkg::SYS_ERROR_POS];
	wire clr_mod   = wr_int & ~reg_wdata[can_fd_irq_pkg::MODE_CHANGE_POS];
	wire clr_tbc   = wr_int & ~reg_wdata[can_fd_irq_pkg::TB_OVERFLOW_POS];

	// First sample after reset only primes the history
	wire mode_changed = opmode_seen & (operating_mode_field != opmode_prev);
	wire system_fault = buffer_overflow_event | address_error_event;

	// Source summaries from live inputs
	wire [31:0] next_rx_pending = {receive_fifo_requests[31:1], 1'b0};
	wire [31:0] next_tx_pending = transmit_fifo_requests;

	// Flag word as seen by software
	wire [15:0] flags = {invalid_message_flag, wakeup_flag, bus_error_flag, system_error_flag,
		receive_overflow_flag, transmit_attempt_flag, host_link_crc_flag, ram_correction_flag,
		3'b000, transmit_event_flag, mode_change_flag, time_base_overflow_flag,
		receive_summary_flag, transmit_summary_flag};
	wire [15:0] active = flags & enables;

	// Priority selection of the summary code, highest code first
	wire [5:0] rx_hit  = highest(receive_fifo_pending_bits);
	wire [5:0] tx_hit  = highest(transmit_fifo_pending_bits);
	wire [5:0] any_hit = highest(receive_fifo_pending_bits | transmit_fifo_pending_bits);
	wire [6:0] serr_code = system_error_is_buffer ? can_fd_irq_pkg::CODE_BUFFER_OVF
		: can_fd_irq_pkg::CODE_ADDR_ERROR;
	wire [6:0] next_interrupt_source_code =
		active[can_fd_irq_pkg::TX_ATTEMPT_POS]  ? can_fd_irq_pkg::CODE_TX_ATTEMPT  :
		active[can_fd_irq_pkg::TX_EVENT_POS]    ? can_fd_irq_pkg::CODE_TX_EVENT    :
		active[can_fd_irq_pkg::INVALID_MSG_POS] ? can_fd_irq_pkg::CODE_INVALID_MSG :
		active[can_fd_irq_pkg::MODE_CHANGE_POS] ? can_fd_irq_pkg::CODE_MODE_CHANGE :
		active[can_fd_irq_pkg::TB_OVERFLOW_POS] ? can_fd_irq_pkg::CODE_TB_OVERFLOW :
		active[can_fd_irq_pkg::SYS_ERROR_POS]   ? serr_code                        :
		active[can_fd_irq_pkg::RX_OVERFLOW_POS] ? can_fd_irq_pkg::CODE_RX_OVERFLOW :
		active[can_fd_irq_pkg::WAKEUP_POS]      ? can_fd_irq_pkg::CODE_WAKEUP      :
		active[can_fd_irq_pkg::BUS_ERROR_POS]   ? can_fd_irq_pkg::CODE_BUS_ERROR   :
		fifo_code(any_hit);

	// Read data selection; unmapped indices read zero
	wire [31:0] tscon_word = {13'h0000, ts_res, ts_eof, time_base_enable, 6'h00, time_base_prescale};
	wire [31:0] vec_word   = {1'b0, receive_source_code, 1'b0, transmit_source_code,
		8'h00, 1'b0, interrupt_source_code};
	wire [31:0] read_word =
		(reg_addr == can_fd_irq_pkg::REG_TIME_BASE_COUNT)       ? time_base_counter          :
		(reg_addr == can_fd_irq_pkg::REG_TIMESTAMP_CONTROL)     ? tscon_word                 :
		(reg_addr == can_fd_irq_pkg::REG_INTERRUPT_CODE_VECTOR) ? vec_word                   :
		(reg_addr == can_fd_irq_pkg::REG_INTERRUPT_ENABLE_FLAG) ? {enables, flags}           :
		(reg_addr == can_fd_irq_pkg::REG_RECEIVE_FIFO_PENDING)  ? receive_fifo_pending_bits  :
		(reg_addr == can_fd_irq_pkg::REG_TRANSMIT_FIFO_PENDING) ? transmit_fifo_pending_bits :
		32'h0000_0000;

	// Time base; setting kept across counter writes
	time_base_counter u_time_base (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.enable     (time_base_enable),
		.prescale   (time_base_prescale),
		.load       (wr_count),
		.load_value (reg_wdata),
		.count      (time_base_counter),
		.wrap       (tb_wrap)
	);

	// Software-owned control fields
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			enables            <= can_fd_irq_pkg::ENABLE_RESET;
			ts_res             <= 1'b0;
			ts_eof             <= 1'b0;
			time_base_enable   <= 1'b0;
			time_base_prescale <= can_fd_irq_pkg::PRESCALE_RESET;
		end else begin
			if (wr_int) begin
				enables <= reg_wdata[31:can_fd_irq_pkg::ENABLE_SHIFT] & can_fd_irq_pkg::ENABLE_MASK;
			end
			if (wr_tscon) begin
				ts_res             <= reg_wdata[can_fd_irq_pkg::TS_RES_POS];
				ts_eof             <= reg_wdata[can_fd_irq_pkg::TS_EOF_POS];
				time_base_enable   <= reg_wdata[can_fd_irq_pkg::TB_ENABLE_POS];
				time_base_prescale <= reg_wdata[can_fd_irq_pkg::TB_PRESCALE_HI:0];
			end
		end
	end

	// Hardware-set, software-cleared flags
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			invalid_message_flag    <= 1'b0;
			wakeup_flag             <= 1'b0;
			bus_error_flag          <= 1'b0;
			system_error_flag       <= 1'b0;
			system_error_is_buffer  <= 1'b0;
			mode_change_flag        <= 1'b0;
			time_base_overflow_flag <= 1'b0;
		end else begin
			invalid_message_flag    <= sticky(invalid_message_flag, clr_ivm, invalid_message_event);
			wakeup_flag             <= sticky(wakeup_flag, clr_wak, wakeup_event);
			bus_error_flag          <= sticky(bus_error_flag, clr_cerr, bus_error_event);
			system_error_flag       <= sticky(system_error_flag, clr_serr, system_fault);
			mode_change_flag        <= sticky(mode_change_flag, clr_mod, mode_changed);
			time_base_overflow_flag <= sticky(time_base_overflow_flag, clr_tbc, tb_wrap);
			// Remember which fault was latest for the code
			if (system_fault) begin
				system_error_is_buffer <= buffer_overflow_event;
			end
		end
	end

	// Mode history
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			opmode_prev <= can_fd_irq_pkg::OPMODE_RESET;
			opmode_seen <= 1'b0;
		end else begin
			opmode_prev <= operating_mode_field;
			opmode_seen <= 1'b1;
		end
	end

	// Read-only mirrors of source conditions; writes do not reach them
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			receive_fifo_pending_bits  <= 32'h0000_0000;
			transmit_fifo_pending_bits <= 32'h0000_0000;
			receive_overflow_flag      <= 1'b0;
			transmit_attempt_flag      <= 1'b0;
			host_link_crc_flag         <= 1'b0;
			ram_correction_flag        <= 1'b0;
			transmit_event_flag        <= 1'b0;
			receive_summary_flag       <= 1'b0;
			transmit_summary_flag      <= 1'b0;
		end else begin
			receive_fifo_pending_bits  <= next_rx_pending;
			transmit_fifo_pending_bits <= next_tx_pending;
			receive_overflow_flag      <= |receive_overflow_bits[31:1];
			transmit_attempt_flag      <= |transmit_attempt_bits;
			host_link_crc_flag         <= host_link_crc_pending;
			ram_correction_flag        <= ram_correction_pending;
			transmit_event_flag        <= transmit_event_pending;
			receive_summary_flag       <= |next_rx_pending;
			transmit_summary_flag      <= |next_tx_pending;
		end
	end

	// Code vector; one cycle behind the flags it encodes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			receive_source_code   <= can_fd_irq_pkg::CODE_NONE;
			transmit_source_code  <= can_fd_irq_pkg::CODE_NONE;
			interrupt_source_code <= can_fd_irq_pkg::CODE_NONE;
		end else begin
			receive_source_code   <= fifo_code(rx_hit);
			transmit_source_code  <= fifo_code(tx_hit);
			interrupt_source_code <= next_interrupt_source_code;
		end
	end

	// Outputs from flops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata   <= 32'h0000_0000;
			reg_rvalid  <= 1'b0;
			interrupt_n <= 1'b1;
		end else begin
			reg_rdata   <= reg_read ? read_word : 32'h0000_0000;
			reg_rvalid  <= reg_read;
			interrupt_n <= ~|active;
		end
	end

	AST_TBC_OVF: assert property (@(posedge sys_clk) disable iff (!rstn)
		tb_wrap |=> time_base_overflow_flag)
		else $error("wrap did not set overflow flag");

	AST_MODE_CHANGE: assert property (@(posedge sys_clk) disable iff (!rstn)
		(opmode_seen && operating_mode_field != opmode_prev) |=> mode_change_flag)
		else $error("mode change not flagged");

	AST_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
		(invalid_message_flag && !wr_int) |=> invalid_message_flag)
		else $error("sticky flag dropped without a write");

	AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!rstn)
		(wakeup_event && clr_wak) |=> wakeup_flag)
		else $error("clear won over a simultaneous set");

	AST_RX_SUMMARY: assert property (@(posedge sys_clk) disable iff (!rstn)
		##1 receive_summary_flag == (|$past(receive_fifo_requests[31:1])))
		else $error("receive summary does not follow FIFO requests");

	AST_RX_BIT0: assert property (@(posedge sys_clk) disable iff (!rstn)
		!receive_fifo_pending_bits[0])
		else $error("receive pending position zero set");

	AST_CODE_NONE: assert property (@(posedge sys_clk) disable iff (!rstn)
		(active == 16'h0000 && any_hit[5] == 1'b0) |=> interrupt_source_code == 7'h40)
		else $error("idle code is not 1000000");

	AST_CODE_ATTEMPT: assert property (@(posedge sys_clk) disable iff (!rstn)
		active[10] |=> interrupt_source_code == 7'h4A)
		else $error("transmit attempt code wrong");

	AST_IRQ: assert property (@(posedge sys_clk) disable iff (!rstn)
		##1 interrupt_n == !(|$past(active)))
		else $error("interrupt output disagrees with enabled flags");

endmodule

`default_nettype wire

// ---- tb/host_port_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Host side of the register port: one strobe per access
module host_port_model (
	input  wire logic        sys_clk,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        reg_rvalid,
	output logic      [2:0]  reg_addr,
	output logic             reg_write,
	output logic             reg_read,
	output logic      [31:0] reg_wdata
);
	// Idle values at time zero
	initial begin
		reg_addr  = 3'h7;
		reg_write = 1'b0;
		reg_read  = 1'b0;
		reg_wdata = 32'h0000_0000;
	end

	// Write taken at one edge; data inverted after so nothing stale lingers
	task automatic write_reg(input logic [2:0] addr, input logic [31:0] data);
		@(negedge sys_clk);
		reg_addr  = addr;
		reg_wdata = data;
		reg_write = 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		reg_write = 1'b0;
		reg_wdata = ~data;
	endtask

	// Answer is registered, so it is looked at mid-cycle after the strobe edge
	task automatic read_reg(input logic [2:0] addr, output logic [31:0] data, output logic valid);
		@(negedge sys_clk);
		reg_addr = addr;
		reg_read = 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		reg_read = 1'b0;
		data     = reg_rdata;
		valid    = reg_rvalid;
	endtask
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam logic [2:0]  a_tbc = can_fd_irq_pkg::REG_TIME_BASE_COUNT;
	localparam logic [2:0]  a_tsc = can_fd_irq_pkg::REG_TIMESTAMP_CONTROL;
	localparam logic [2:0]  a_vec = can_fd_irq_pkg::REG_INTERRUPT_CODE_VECTOR;
	localparam logic [2:0]  a_int = can_fd_irq_pkg::REG_INTERRUPT_ENABLE_FLAG;
	localparam logic [2:0]  a_rx  = can_fd_irq_pkg::REG_RECEIVE_FIFO_PENDING;
	localparam logic [2:0]  a_tx  = can_fd_irq_pkg::REG_TRANSMIT_FIFO_PENDING;
	localparam logic [31:0] en    = 32'hFF1F_0000;
	localparam int          epos[6]  = '{15, 14, 13, 12, 12, 3};
	localparam logic [31:0] ecode[6] = '{32'h48, 32'h42, 32'h41, 32'h45, 32'h44, 32'h47};
	localparam int          lpos[5]  = '{9, 8, 4, 11, 10};
	localparam logic [31:0] lcode[5] = '{32'h40, 32'h40, 32'h49, 32'h43, 32'h4A};

	logic        sys_clk = 1'b0;
	logic        rstn;
	logic [2:0]  reg_addr;
	logic        reg_write;
	logic        reg_read;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        reg_rvalid;
	logic        interrupt_n;
	logic [2:0]  mode;
	logic [4:0]  ev;
	logic [4:0]  lvl;
	logic [31:0] rq;
	logic [31:0] tq;
	logic [31:0] t0;
	logic [31:0] t1;
	int          bad_count = 0;
	int          tests_run = 0;

	// 10 MHz system clock
	always #50 sys_clk = ~sys_clk;

	host_port_model host (
		.sys_clk   (sys_clk),
		.reg_rdata (reg_rdata),
		.reg_rvalid(reg_rvalid),
		.reg_addr  (reg_addr),
		.reg_write (reg_write),
		.reg_read  (reg_read),
		.reg_wdata (reg_wdata)
	);

	can_fd_interrupt_and_time_base dut (
		.sys_clk               (sys_clk),
		.rstn                  (rstn),
		.reg_addr              (reg_addr),
		.reg_write             (reg_write),
		.reg_read              (reg_read),
		.reg_wdata             (reg_wdata),
		.operating_mode_field  (mode),
		.invalid_message_event (ev[0]),
		.wakeup_event          (ev[1]),
		.bus_error_event       (ev[2]),
		.buffer_overflow_event (ev[3]),
		.address_error_event   (ev[4]),
		.receive_overflow_bits ({28'h0, lvl[3], 3'h0}),
		.transmit_attempt_bits ({31'h0, lvl[4]}),
		.host_link_crc_pending (lvl[0]),
		.ram_correction_pending(lvl[1]),
		.transmit_event_pending(lvl[2]),
		.receive_fifo_requests (rq),
		.transmit_fifo_requests(tq),
		.reg_rdata             (reg_rdata),
		.reg_rvalid            (reg_rvalid),
		.interrupt_n           (interrupt_n)
	);

	// Single comparison point
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rd(input logic [2:0] a, output logic [31:0] d);
		logic v;
		host.read_reg(a, d, v);
		check("read valid", {31'h0, v}, 32'h1);
	endtask

	task automatic rdc(input string name, input logic [2:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		check(name, d, exp);
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		finish_test();
	end

	// Main sequence
	initial begin
		rstn = 1'b0;
		mode = 3'h0;
		ev   = 5'h00;
		lvl  = 5'h00;
		rq   = 32'h0;
		tq   = 32'h0;
		repeat (20) @(negedge sys_clk);
		rstn = 1'b1;
		rdc("count", a_tbc, 32'h0);
		rdc("control", a_tsc, 32'h0);
		rdc("vector", a_vec, 32'h4040_0040);
		rdc("int", a_int, 32'h0);
		rdc("rx bits", a_rx, 32'h0);
		rdc("unmapped", 3'h6, 32'h0);
		check("irq idle", {31'h0, interrupt_n}, 32'h1);
		host.write_reg(a_vec, 32'hFFFF_FFFF);
		rdc("vector ro", a_vec, 32'h4040_0040);
		host.write_reg(a_int, 32'hFFFF_FFFF);
		rdc("enables", a_int, en);
		$display("test reset done");
		// Hardware-set flags, one source at a time
		for (int i = 0; i < 6; i++) begin
			if (i == 5) mode = mode + 3'h3;
			else ev[i] = 1'b1;
			@(negedge sys_clk);
			ev = 5'h00;
			repeat (2) @(negedge sys_clk);
			rdc("event flag", a_int, en | (32'h1 << epos[i]));
			rdc("event code", a_vec, 32'h4040_0000 | ecode[i]);
			check("irq set", {31'h0, interrupt_n}, 32'h0);
			host.write_reg(a_int, en);
			rdc("event clear", a_int, en);
			check("irq clear", {31'h0, interrupt_n}, 32'h1);
		end
		$display("test events done");
		// Source levels: a write of zero must not clear them
		for (int i = 0; i < 5; i++) begin
			lvl[i] = 1'b1;
			repeat (3) @(negedge sys_clk);
			rdc("level flag", a_int, en | (32'h1 << lpos[i]));
			// Link CRC and RAM correction carry no code of their own
			rdc("level code", a_vec, 32'h4040_0000 | lcode[i]);
			host.write_reg(a_int, en);
			rdc("level kept", a_int, en | (32'h1 << lpos[i]));
			lvl[i] = 1'b0;
			repeat (3) @(negedge sys_clk);
			rdc("level gone", a_int, en);
		end
		$display("test levels done");
		// FIFO summaries and codes; bit 0 of receive ignored
		rq = 32'h0000_0025;
		tq = 32'h8000_0001;
		repeat (3) @(negedge sys_clk);
		rdc("rx bits", a_rx, 32'h0000_0024);
		rdc("tx bits", a_tx, 32'h8000_0001);
		rdc("summaries", a_int, en | 32'h3);
		rdc("fifo codes", a_vec, 32'h051F_001F);
		tq = 32'h1;
		lvl[3] = 1'b1;
		repeat (3) @(negedge sys_clk);
		rdc("queue code", a_vec, 32'h0500_0043);
		rq = 32'h0;
		tq = 32'h0;
		lvl = 5'h00;
		repeat (3) @(negedge sys_clk);
		rdc("rx idle", a_rx, 32'h0);
		rdc("fifo idle", a_vec, 32'h4040_0040);
		$display("test fifos done");
		// Masked source: flag seen, no output, no code
		host.write_reg(a_int, 32'h0);
		ev[1] = 1'b1;
		@(negedge sys_clk);
		ev = 5'h00;
		repeat (2) @(negedge sys_clk);
		rdc("masked flag", a_int, 32'h0000_4000);
		rdc("masked code", a_vec, 32'h4040_0040);
		check("irq masked", {31'h0, interrupt_n}, 32'h1);
		host.write_reg(a_int, en);
		// Wake event in the very cycle of a clearing write: the set wins
		fork
			host.write_reg(a_int, en);
			begin
				@(negedge sys_clk);
				ev[1] = 1'b1;
				@(negedge sys_clk);
				ev = 5'h00;
			end
		join
		rdc("set wins", a_int, en | 32'h0000_4000);
		host.write_reg(a_int, en);
		rdc("set cleared", a_int, en);
		$display("test mask done");
		// Time base at prescale 3: one count per four clocks
		host.write_reg(a_tsc, 32'h0001_0003);
		rd(a_tbc, t0);
		repeat (38) @(negedge sys_clk);
		rd(a_tbc, t1);
		check("tb rate", t1 - t0, 32'h0000_000A);
		host.write_reg(a_tbc, 32'hFFFF_FFFE);
		// Restarted prescaler: no step within the first clocks after the load
		rdc("count loaded", a_tbc, 32'hFFFF_FFFE);
		rdc("prescale kept", a_tsc, 32'h0001_0003);
		repeat (20) @(negedge sys_clk);
		rdc("wrap flag", a_int, en | 32'h4);
		rdc("wrap code", a_vec, 32'h4040_0046);
		host.write_reg(a_tsc, 32'h0000_0003);
		rdc("tb stopped", a_tbc, 32'h0);
		repeat (10) @(negedge sys_clk);
		rdc("tb held", a_tbc, 32'h0);
		rdc("wrap sticky", a_int, en | 32'h4);
		host.write_reg(a_int, en);
		rdc("wrap cleared", a_int, en);
		$display("test time base done");
		finish_test();
	end
endmodule

`default_nettype wire
